// >>> include/sfm_params.svh
// Constants for the stepper fault and mode control block.
// What this block does
// RULE1 - Over-temperature turns off every bridge transistor and pulls fault output low.
// RULE2 - After temperature clears, bridges resume alone; fault output releases afterwards.
// RULE3 - Supply lockout disables all circuitry and resets all logic including indexer; code leaves early_r and the synchronisers unreset.
// RULE4 - Fault output stays low during lockout; released after operation restarts.
// RULE5 - No fault indication latches; everything clears when the fault goes away.
// RULE6 - Overcurrent keeps logic running, bridge off, drives again after retry wait.
// RULE7 - Sleep input low disables regulator and indexer; bridges go high impedance.
// RULE8 - Sleep is entered only after the entry delay from the sleep falling edge.
// RULE9 - After sleep rises, outputs hold until the wake delay has passed.
// RULE10 - Output disable high turns bridges off; step edges still advance indexer.
// RULE11 - Bridges resume at the current indexer position when output disable drops.
// RULE12 - Fault mode disables bridges; regulator and indexer depend on the fault.
// RULE13 - Fixed off-time chopping: at threshold, decay runs until the cycle expires.
// RULE14 - Four decay behaviours: slow, fast, mixed and automatically adjusting.
// RULE15 - Chop comparator ignored for blanking after each drive start.
// RULE16 - Indexer resolution full step to thirty-second step via microstep select.
// RULE17 - Chop threshold from sense against reference over gain, scaled by torque.
// RULE18 - Overcurrent acts only after the deglitch time; disables bridge, pulls fault.
// RULE19 - Overcurrent detection, shutdown and retry are tracked per bridge.
// RULE20 - Step, sleep and output-disable inputs are synchronised before use.
// RULE21 - With several faults active, fault output stays low until all clear.
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH
`define SFM_CLK_MHZ 100
`define SFM_SLEEP_US 1
`define SFM_WAKE_US 1
`define SFM_OCP_US 3
`define SFM_RETRY_US 1600
`define SFM_TOFF_US 20
`define SFM_BLANK_NS 1800
`define SFM_SLEEP_CYC (`SFM_SLEEP_US * `SFM_CLK_MHZ)
`define SFM_WAKE_CYC (`SFM_WAKE_US * `SFM_CLK_MHZ)
`define SFM_OCP_CYC (`SFM_OCP_US * `SFM_CLK_MHZ)
`define SFM_RETRY_CYC (`SFM_RETRY_US * `SFM_CLK_MHZ)
`define SFM_TOFF_CYC (`SFM_TOFF_US * `SFM_CLK_MHZ)
`define SFM_BLANK_CYC ((`SFM_BLANK_NS * `SFM_CLK_MHZ + 999) / 1000)
`define SFM_GAIN_X10 66
`define SFM_FAST_QTR 4
`endif

// >>> include/sfm_pkg.sv
// Types for the stepper fault and mode control block.
package sfm_pkg;
  typedef enum logic [1:0] {
    SFM_DECAY_SLOW,
    SFM_DECAY_FAST,
    SFM_DECAY_MIXED,
    SFM_DECAY_AUTO
  } sfm_decay_t;
  typedef enum logic [1:0] {
    SFM_ACTIVE,
    SFM_ENTERING,
    SFM_ASLEEP,
    SFM_WAKING
  } sfm_pwr_t;
  typedef enum logic [1:0] {
    SFM_DRIVE,
    SFM_DECAY
  } sfm_chop_t;
endpackage

// >>> rtl/sfm_ctrl.sv
// Fault handling, sleep, disable, indexer and chopping control.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module sfm_ctrl #(
  parameter int RETRY_CYC = `SFM_RETRY_CYC,
  parameter int OCP_CYC = `SFM_OCP_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic sleep_req_n,
  input wire logic output_disable_n,
  input wire logic supply_lockout,
  input wire logic thermal_trip,
  input wire logic [1:0] overcurrent_trip,
  input wire logic [2:0] microstep_select,
  input wire sfm_pkg::sfm_decay_t decay_sel,
  input wire logic [7:0] sense_input_a,
  input wire logic [7:0] sense_input_b,
  input wire logic [7:0] vref_code,
  input wire logic [2:0] torque,
  output logic fault_out_n,
  output logic internal_regulator,
  output logic [1:0] bridge_on,
  output logic [1:0] bridge_fast,
  output logic [1:0] bridge_hiz,
  output logic [7:0] index_pos,
  output logic [7:0] out_pos,
  output logic [7:0] chop_current
);
  import sfm_pkg::*;
  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [3:0] meta_r, sync_r;
  logic step_d_r;
  // RULE20 two-flop synchronisers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 4'h2;
      sync_r <= 4'h2;
      step_d_r <= 1'b0;
    end else begin
      meta_r <= {dir_in, output_disable_n, sleep_req_n, step_in};
      sync_r <= meta_r;
      step_d_r <= sync_r[0];
    end
  end
  logic step_s, sleep_s, odis_s, dir_s, step_rise;
  assign step_s = sync_r[0];
  assign sleep_s = sync_r[1];
  assign odis_s = sync_r[2];
  assign dir_s = sync_r[3];
  assign step_rise = step_s && !step_d_r;
  // ------------------------------------------------------------------
  // Sleep and wake sequencing
  // ------------------------------------------------------------------
  sfm_pwr_t pwr_r, pwr_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;
  always_comb begin
    pwr_nxt = pwr_r;
    pcnt_nxt = 16'h0;
    unique case (pwr_r)
      SFM_ACTIVE: if (!sleep_s) pwr_nxt = SFM_ENTERING;
      // RULE8 entry delay
      SFM_ENTERING: begin
        pcnt_nxt = pcnt_r + 16'h1;
        if (sleep_s) pwr_nxt = SFM_ACTIVE;
        else if (pcnt_r == 16'(`SFM_SLEEP_CYC - 1)) pwr_nxt = SFM_ASLEEP;
      end
      SFM_ASLEEP: if (sleep_s) pwr_nxt = SFM_WAKING;
      // RULE9 wake delay
      SFM_WAKING: begin
        pcnt_nxt = pcnt_r + 16'h1;
        if (!sleep_s) pwr_nxt = SFM_ASLEEP;
        else if (pcnt_r == 16'(`SFM_WAKE_CYC - 1)) pwr_nxt = SFM_ACTIVE;
      end
    endcase
  end
  // RULE3 lockout resets the sequencer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwr_r <= SFM_ACTIVE;
      pcnt_r <= 16'h0;
    end else if (supply_lockout) begin
      pwr_r <= SFM_ACTIVE;
      pcnt_r <= 16'h0;
    end else begin
      pwr_r <= pwr_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end
  logic asleep, running;
  assign asleep = (pwr_r == SFM_ASLEEP) || (pwr_r == SFM_WAKING);
  // RULE7 regulator and indexer off in sleep
  assign running = !asleep && !supply_lockout;
  // ------------------------------------------------------------------
  // Overcurrent per bridge
  // ------------------------------------------------------------------
  logic [1:0] oc_trip_r;
  logic [1:0] oc_trip_nxt;
  logic [31:0] oc_cnt_r [2];
  logic [31:0] oc_cnt_nxt [2];
  // RULE19 per-bridge tracking
  for (genvar b = 0; b < 2; b++) begin : g_oc
    always_comb begin
      oc_trip_nxt[b] = oc_trip_r[b];
      oc_cnt_nxt[b] = 32'h0;
      if (!oc_trip_r[b]) begin
        // RULE18 deglitch before acting
        if (overcurrent_trip[b]) begin
          oc_cnt_nxt[b] = oc_cnt_r[b] + 32'h1;
          if (oc_cnt_r[b] == 32'(OCP_CYC - 1)) begin
            oc_trip_nxt[b] = 1'b1;
            oc_cnt_nxt[b] = 32'h0;
          end
        end
      end else begin
        // RULE6 retry wait then drive again
        oc_cnt_nxt[b] = oc_cnt_r[b] + 32'h1;
        if (oc_cnt_r[b] == 32'(RETRY_CYC - 1)) begin
          oc_trip_nxt[b] = 1'b0;
          oc_cnt_nxt[b] = 32'h0;
        end
      end
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        oc_trip_r[b] <= 1'b0;
        oc_cnt_r[b] <= 32'h0;
      end else if (supply_lockout || asleep) begin
        oc_trip_r[b] <= 1'b0;
        oc_cnt_r[b] <= 32'h0;
      end else begin
        oc_trip_r[b] <= oc_trip_nxt[b];
        oc_cnt_r[b] <= oc_cnt_nxt[b];
      end
    end
  end
  // ------------------------------------------------------------------
  // Indexer
  // ------------------------------------------------------------------
  logic [7:0] idx_r, idx_nxt, hold_r, hold_nxt;
  logic [7:0] stride;
  // RULE16 full to thirty-second step
  always_comb begin
    stride = 8'h1;
    if (microstep_select <= 3'h5)
      stride = 8'(8'h20 >> microstep_select);
  end
  always_comb begin
    idx_nxt = idx_r;
    // RULE10 step advances while disabled
    if (step_rise)
      idx_nxt = dir_s ? idx_r + stride : idx_r - stride;
    hold_nxt = hold_r;
    // RULE11 outputs take position when enabled
    if (!odis_s) hold_nxt = idx_r;
  end
  // RULE3 lockout resets indexer state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idx_r <= 8'h0;
      hold_r <= 8'h0;
    end else if (supply_lockout || asleep) begin
      idx_r <= 8'h0;
      hold_r <= 8'h0;
    end else begin
      idx_r <= idx_nxt;
      hold_r <= hold_nxt;
    end
  end
  // ------------------------------------------------------------------
  // Chopping per bridge
  // ------------------------------------------------------------------
  logic [15:0] thresh;
  // RULE17 reference over gain, scaled by (8 - torque)
  always_comb begin
    thresh = 16'((32'(vref_code) * 32'd80 * (32'd8 - 32'(torque)))
                 / (32'd8 * `SFM_GAIN_X10));
  end
  logic [7:0] sense [2];
  assign sense[0] = sense_input_a;
  assign sense[1] = sense_input_b;
  sfm_chop_t ch_r [2];
  sfm_chop_t ch_nxt [2];
  logic [11:0] ct_r [2];
  logic [11:0] ct_nxt [2];
  logic [1:0] fast_r, fast_nxt, early_r, early_nxt;
  logic [1:0] drv_en;
  for (genvar b = 0; b < 2; b++) begin : g_chop
    always_comb begin
      ch_nxt[b] = ch_r[b];
      ct_nxt[b] = ct_r[b] + 12'h1;
      fast_nxt[b] = fast_r[b];
      early_nxt[b] = early_r[b];
      unique case (ch_r[b])
        SFM_DRIVE: begin
          // RULE15 blanking ignores comparator
          if (ct_r[b] >= 12'(`SFM_BLANK_CYC) &&
              16'(sense[b]) >= thresh) begin
            // RULE13 enter decay at threshold
            ch_nxt[b] = SFM_DECAY;
            early_nxt[b] = (ct_r[b] == 12'(`SFM_BLANK_CYC));
            ct_nxt[b] = 12'h0;
          end
        end
        SFM_DECAY: begin
          // RULE14 four decay behaviours
          unique case (decay_sel)
            SFM_DECAY_SLOW: fast_nxt[b] = 1'b0;
            SFM_DECAY_FAST: fast_nxt[b] = 1'b1;
            SFM_DECAY_MIXED:
              fast_nxt[b] = ct_r[b] < 12'(`SFM_TOFF_CYC / `SFM_FAST_QTR);
            SFM_DECAY_AUTO: fast_nxt[b] = early_r[b] &&
              ct_r[b] < 12'(`SFM_TOFF_CYC / `SFM_FAST_QTR);
          endcase
          if (ct_r[b] == 12'(`SFM_TOFF_CYC - 1)) begin
            ch_nxt[b] = SFM_DRIVE;
            ct_nxt[b] = 12'h0;
            fast_nxt[b] = 1'b0;
          end
        end
      endcase
      if (!drv_en[b]) begin
        ch_nxt[b] = SFM_DRIVE;
        ct_nxt[b] = 12'h0;
        fast_nxt[b] = 1'b0;
      end
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        ch_r[b] <= SFM_DRIVE;
        ct_r[b] <= 12'h0;
        fast_r[b] <= 1'b0;
        early_r[b] <= 1'b0;
      end else begin
        ch_r[b] <= ch_nxt[b];
        ct_r[b] <= ct_nxt[b];
        fast_r[b] <= fast_nxt[b];
        early_r[b] <= early_nxt[b];
      end
    end
  end
  // ------------------------------------------------------------------
  // Bridge enables and fault output
  // ------------------------------------------------------------------
  // RULE1 RULE12 faults disable bridges
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      drv_en[b] = running && !thermal_trip && !oc_trip_r[b] && !odis_s;
    end
  end
  logic fault_any, fault_r, fault_d_r;
  // RULE5 RULE21 unlatched, low while any fault
  assign fault_any = supply_lockout || thermal_trip || (|oc_trip_r);
  // RULE2 RULE4 release after bridges resume
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_r <= 1'b0;
      fault_d_r <= 1'b0;
      bridge_on <= 2'h0;
      bridge_fast <= 2'h0;
      bridge_hiz <= 2'h3;
      out_pos <= 8'h0;
    end else begin
      fault_r <= fault_any;
      fault_d_r <= fault_r;
      for (int b = 0; b < 2; b++) begin
        bridge_on[b] <= drv_en[b] && ch_r[b] == SFM_DRIVE;
        bridge_fast[b] <= drv_en[b] && fast_r[b];
        bridge_hiz[b] <= !drv_en[b];
      end
      out_pos <= hold_r;
    end
  end
  assign fault_out_n = !(fault_d_r || fault_r || fault_any);
  assign internal_regulator = running;
  assign index_pos = idx_r;
  assign chop_current = thresh[7:0];
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_thermal_off: assert property ( // RULE1
    @(posedge mclk) disable iff (!nrst)
    thermal_trip |=> bridge_hiz == 2'h3 && !fault_out_n)
    else $error("bridges not off on thermal trip");
  a_lockout_fault: assert property ( // RULE4
    @(posedge mclk) disable iff (!nrst)
    supply_lockout |-> !fault_out_n && !internal_regulator)
    else $error("lockout not reported");
  a_lockout_reset: assert property ( // RULE3
    @(posedge mclk) disable iff (!nrst)
    supply_lockout |=> idx_r == 8'h0)
    else $error("indexer not reset under lockout");
  a_fault_clears: assert property ( // RULE5
    @(posedge mclk) disable iff (!nrst)
    !fault_any ##1 !fault_any ##1 !fault_any |-> fault_out_n)
    else $error("fault indication latched");
  a_disable_hold: assert property ( // RULE11
    @(posedge mclk) disable iff (!nrst)
    odis_s && $past(odis_s) && !$past(supply_lockout) && !$past(asleep)
    |=> $stable(out_pos))
    else $error("outputs moved while disabled");
  a_disable_off: assert property ( // RULE10
    @(posedge mclk) disable iff (!nrst)
    odis_s |=> bridge_on == 2'h0)
    else $error("bridge on while disabled");
  a_sleep_entry: assert property ( // RULE8
    @(posedge mclk) disable iff (!nrst)
    pwr_r == SFM_ACTIVE && !sleep_s && !supply_lockout |=> !asleep)
    else $error("sleep entered early");
  a_sleep_off: assert property ( // RULE7
    @(posedge mclk) disable iff (!nrst)
    asleep |=> bridge_hiz == 2'h3)
    else $error("bridges driven in sleep");
  a_blank_min: assert property ( // RULE15
    @(posedge mclk) disable iff (!nrst)
    ch_r[0] == SFM_DRIVE && ct_r[0] < 12'(`SFM_BLANK_CYC) && drv_en[0]
    |=> ch_r[0] == SFM_DRIVE)
    else $error("chop during blanking");
endmodule // sfm_ctrl
`default_nettype wire

// >>> tb/sfm_ctl_model.sv
// Motion controller model that drives the step and control pins.
`timescale 1ns/1ps
`default_nettype none
module sfm_ctl_model (
  input wire logic mclk,
  output logic step_in,
  output logic dir_in,
  output logic sleep_req_n,
  output logic output_disable_n
);
  initial begin
    step_in = 1'b0;
    dir_in = 1'b1;
    sleep_req_n = 1'b1;
    output_disable_n = 1'b0;
  end
  task automatic pulse_step();
    @(posedge mclk);
    step_in <= 1'b1;
    repeat (4) @(posedge mclk);
    step_in <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // level only, motion checked after wake delay
  task automatic set_sleep(input logic v);
    @(posedge mclk);
    sleep_req_n <= v;
  endtask
  task automatic set_dis(input logic v);
    @(posedge mclk);
    output_disable_n <= v;
  endtask
  task automatic set_dir(input logic v);
    @(posedge mclk);
    dir_in <= v;
  endtask
endmodule // sfm_ctl_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the stepper fault and mode control.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfm_pkg::*;
  localparam int RETRY = 50;
  localparam int OCPC = 4;
  localparam int FLO [4] = '{0, 1990, 495, 495};
  localparam int FHI [4] = '{0, 2002, 505, 505};
  logic mclk, nrst, step_in, dir_in, sleep_req_n, output_disable_n;
  logic supply_lockout, thermal_trip, fault_out_n, internal_regulator;
  logic [1:0] overcurrent_trip, bridge_on, bridge_fast, bridge_hiz;
  logic [2:0] microstep_select, torque;
  logic [7:0] sense_a, sense_b, vref_code, index_pos, out_pos, chop_current;
  sfm_decay_t decay_sel;
  int n_fail, checks, on_c, off_c, fast_c;
  logic [7:0] exp_pos, held;
  sfm_ctl_model mdl (.mclk(mclk), .step_in(step_in), .dir_in(dir_in),
    .sleep_req_n(sleep_req_n), .output_disable_n(output_disable_n));
  sfm_ctrl #(.RETRY_CYC(RETRY), .OCP_CYC(OCPC)) dut (.mclk(mclk),
    .nrst(nrst), .step_in(step_in), .dir_in(dir_in),
    .sleep_req_n(sleep_req_n), .output_disable_n(output_disable_n),
    .supply_lockout(supply_lockout), .thermal_trip(thermal_trip),
    .overcurrent_trip(overcurrent_trip),
    .microstep_select(microstep_select), .decay_sel(decay_sel),
    .sense_input_a(sense_a), .sense_input_b(sense_b),
    .vref_code(vref_code), .torque(torque), .fault_out_n(fault_out_n),
    .internal_regulator(internal_regulator), .bridge_on(bridge_on),
    .bridge_fast(bridge_fast), .bridge_hiz(bridge_hiz),
    .index_pos(index_pos), .out_pos(out_pos), .chop_current(chop_current));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic measure();
    int g;
    g = 0;
    on_c = 0;
    off_c = 0;
    fast_c = 0;
    while (bridge_on[0] !== 1'b0 && g < 5000) begin
      tick(1);
      g++;
    end
    while (bridge_on[0] !== 1'b1 && g < 5000) begin
      tick(1);
      g++;
    end
    while (bridge_on[0] === 1'b1 && g < 5000) begin
      tick(1);
      g++;
      on_c++;
    end
    while (bridge_on[0] === 1'b0 && g < 5000) begin
      tick(1);
      g++;
      off_c++;
      if (bridge_fast[0] === 1'b1) fast_c++;
    end
    if (g >= 5000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    supply_lockout = 1'b0;
    thermal_trip = 1'b0;
    overcurrent_trip = 2'b00;
    microstep_select = 3'h0;
    torque = 3'h0;
    sense_a = 8'hFF;
    sense_b = 8'h00;
    vref_code = 8'h42;
    decay_sel = SFM_DECAY_SLOW;
    n_fail = 0;
    checks = 0;
    exp_pos = 8'h00;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    tick(3);
    chk(fault_out_n, 1'b1);
    chk(index_pos, 8'h00);
    chk(chop_current, 8'h50);
    @(posedge mclk);
    torque <= 3'h4;
    tick(2);
    chk(chop_current, 8'h28);
    @(posedge mclk);
    torque <= 3'h0;
    $display("reset and threshold test done");
    for (int s = 0; s < 6; s++) begin
      @(posedge mclk);
      microstep_select <= s[2:0];
      mdl.pulse_step();
      exp_pos = exp_pos + (8'h20 >> s);
      tick(1);
      chk(index_pos, exp_pos);
      chk(out_pos, exp_pos);
    end
    $display("step resolution test done");
    mdl.set_dis(1'b1);
    tick(4);
    chk(bridge_hiz, 2'b11);
    held = out_pos;
    mdl.pulse_step();
    tick(1);
    chk(index_pos, exp_pos + 8'h01);
    chk(out_pos, held);
    mdl.set_dis(1'b0);
    tick(4);
    chk(out_pos, exp_pos + 8'h01);
    chk(bridge_hiz, 2'b00);
    $display("output disable test done");
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      decay_sel <= sfm_decay_t'(m);
      measure();
      measure();
      chk(16'(on_c >= 180 && on_c <= 182), 16'h1);
      chk(16'(off_c >= 1998 && off_c <= 2002), 16'h1);
      chk(16'(fast_c >= FLO[m] && fast_c <= FHI[m]), 16'h1);
    end
    $display("chopping test done");
    @(posedge mclk);
    thermal_trip <= 1'b1;
    #1;
    chk(fault_out_n, 1'b0);
    tick(1);
    chk(bridge_hiz, 2'b11);
    @(posedge mclk);
    thermal_trip <= 1'b0;
    #1;
    chk(fault_out_n, 1'b0);
    tick(1);
    chk(bridge_hiz, 2'b00);
    chk(fault_out_n, 1'b0);
    tick(1);
    chk(fault_out_n, 1'b1);
    $display("thermal test done");
    @(posedge mclk);
    thermal_trip <= 1'b1;
    supply_lockout <= 1'b1;
    tick(3);
    chk(internal_regulator, 1'b0);
    chk(index_pos, 8'h00);
    @(posedge mclk);
    thermal_trip <= 1'b0;
    tick(3);
    chk(fault_out_n, 1'b0);
    @(posedge mclk);
    supply_lockout <= 1'b0;
    tick(1);
    chk(fault_out_n, 1'b0);
    chk(internal_regulator, 1'b1);
    tick(2);
    chk(fault_out_n, 1'b1);
    $display("lockout test done");
    @(posedge mclk);
    overcurrent_trip <= 2'b01;
    tick(2);
    @(posedge mclk);
    overcurrent_trip <= 2'b00;
    tick(3);
    chk(fault_out_n, 1'b1);
    @(posedge mclk);
    overcurrent_trip <= 2'b01;
    tick(OCPC + 3);
    chk(fault_out_n, 1'b0);
    chk(bridge_hiz, 2'b01);
    @(posedge mclk);
    overcurrent_trip <= 2'b00;
    mdl.pulse_step();
    tick(1);
    chk(index_pos, 8'h01);
    chk(bridge_hiz, 2'b01);
    mdl.set_dir(1'b0);
    mdl.pulse_step();
    tick(1);
    chk(index_pos, 8'h00);
    tick(RETRY + 5);
    chk(bridge_hiz, 2'b00);
    chk(fault_out_n, 1'b1);
    $display("overcurrent test done");
    mdl.set_sleep(1'b0);
    tick(50);
    chk(internal_regulator, 1'b1);
    chk(bridge_hiz, 2'b00);
    tick(60);
    chk(internal_regulator, 1'b0);
    chk(bridge_hiz, 2'b11);
    mdl.set_sleep(1'b1);
    tick(50);
    chk(bridge_hiz, 2'b11);
    tick(60);
    chk(bridge_hiz, 2'b00);
    $display("sleep test done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
